// ==== src/ai_fmt_consts.svh ====
/*
  constants of the analog input value formatter: offsets, field positions,
  reset values, codes and timing counts. assumes a 20 MHz system clock.
*/
`ifndef AI_FMT_CONSTS_SVH
`define AI_FMT_CONSTS_SVH
`define CLK_HZ 20000000
`define RESERVED_BYTE_OFS 8'h00
`define FILTER_SELECT_OFS 8'h01
`define PARAM_LAST_OFS 8'h0c
`define CH0_RESULT_ADDR 16'h0320
`define CH1_RESULT_ADDR 16'h0322
`define FILTER_SELECT_RST 8'h10
`define FILT_CH0_LSB 0
`define FILT_CH1_LSB 2
`define SIGN_BIT 15
`define LOW_ZERO_BITS 4
`define FILT_SMALL_SHIFT 4'h6
`define FILT_MEDIUM_SHIFT 4'h9
`define CODE_OVERFLOW 16'h7fff
`define CODE_UNDERFLOW 16'h8000
`define CODE_PARAM_ERR 16'h7fff
`define CODE_TOP_OVERDRIVE 16'sh7eff
`define CODE_BOT_UNDERDRIVE 16'shf75c
`define SETTLE_MS 2
`define SETTLE_CYCLES (`SETTLE_MS * (`CLK_HZ / 1000))
`define T_NONE_MS 2
`define T_SMALL_MS 100
`define T_MEDIUM_MS 1000
`define SAMPLE_US 50
`define SAMPLE_CYCLES (`SAMPLE_US * (`CLK_HZ / 1000000))
`endif

// ==== src/ai_fmt_pkg.sv ====
/*
  types of the analog input value formatter.
  assumes ai_fmt_consts.svh supplies the numbers.
*/
package ai_fmt_pkg;
  typedef enum logic [1:0] {
    FILT_NONE = 2'b00,
    FILT_SMALL = 2'b01,
    FILT_MEDIUM = 2'b10,
    FILT_BAD = 2'b11
  } filter_mode_t;
  typedef enum {ST_RUN, ST_SETTLE} chan_state_t;
endpackage : ai_fmt_pkg

// ==== src/chan_filter.sv ====
/*
  one channel: first-order smoothing of raw converter codes, then clamping
  and formatting into the result word. assumes the raw code and its strobe
  come from logic on the same clock, sign extended, scaled 27648 per 10 V.
*/
`timescale 1ns/1ps
`include "ai_fmt_consts.svh"
module chan_filter
  import ai_fmt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire ai_fmt_pkg::filter_mode_t mode,
  input wire logic settling,
  // raw sample
  input wire logic sample_stb,
  input wire logic signed [16:0] raw_code,
  // result
  output logic [15:0] result_r
);
  logic signed [27:0] acc_r;
  logic signed [27:0] acc_nxt;
  logic signed [27:0] raw_ext;
  logic [3:0] shift;
  logic signed [16:0] smooth;
  logic [15:0] fmt;
  logic [15:0] result_nxt;
  // shift sets time constants of 64 and 512 samples, well below the filter time constants at the sample rate
  assign shift = (mode == FILT_SMALL) ? `FILT_SMALL_SHIFT :
                 (mode == FILT_MEDIUM) ? `FILT_MEDIUM_SHIFT : 4'h0;
  assign smooth = 17'(acc_r >>> 10);
  // a concatenation is unsigned, so the sign bit is repeated by hand
  assign raw_ext = {raw_code[16], raw_code, 10'h000};
  assign acc_nxt = (mode == FILT_NONE) ? raw_ext :
                   28'(acc_r + ((raw_ext - acc_r) >>> shift));
  // magnitude below 11 bits plus sign is cleared
  assign fmt = {smooth[15:`LOW_ZERO_BITS], 4'h0};
  assign result_nxt =
    (settling || mode == FILT_BAD) ? `CODE_PARAM_ERR :
    (smooth > 17'(`CODE_TOP_OVERDRIVE)) ? `CODE_OVERFLOW :
    (smooth < 17'(`CODE_BOT_UNDERDRIVE)) ? `CODE_UNDERFLOW :
    fmt;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_r <= 28'sh0;
    end else if (sample_stb) begin
      acc_r <= acc_nxt;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      result_r <= 16'h0000;
    end else begin
      result_r <= result_nxt;
    end
  end
endmodule : chan_filter

// ==== src/analog_input_value_formatter.sv ====
/*
  two-channel analog input value formatter: parameter record write port,
  input-image word read port, per-channel filter and result formatting.
  assumes raw converter codes arrive from same-clock logic with a strobe,
  and that the parameter and image ports are driven synchronously to clk.
*/
`timescale 1ns/1ps
`include "ai_fmt_consts.svh"
// Behaviour
// - result is 16-bit two's complement, bit 15 set means negative
// - 11 magnitude bits plus sign, left aligned, low bits zero
// - above overdrive region the result is 32767
// - below underdrive region the result is -32768
// - invalid channel parameters give 32767
// - code is 27648 times voltage over 10, linear
// - linear codes continue to 32511 at top and -2212 at bottom
// - byte 1 bits 1:0 filter channel 0, bits 3:2 channel 1
// - after reset byte 1 holds 10h, medium filter
// - new parameters take effect within 2 ms, result reads 7fffh meanwhile
// - channel 0 word at input address 800, channel 1 at 802
module analog_input_value_formatter
  import ai_fmt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // raw converter codes
  input wire logic sample_stb,
  input wire logic signed [16:0] raw_ch0,
  input wire logic signed [16:0] raw_ch1,
  // parameter record write (record 1)
  input wire logic param_wr,
  input wire logic [7:0] param_addr,
  input wire logic [7:0] param_wdata,
  // parameter record read back
  input wire logic param_rd,
  output logic [7:0] param_rdata_r,
  // input image word read
  input wire logic image_rd,
  input wire logic [15:0] image_addr,
  output logic [15:0] image_rdata_r,
  output logic image_ack_r,
  // status
  output logic settling_r
);
  import ai_fmt_pkg::*;

  // stored record byte and settle window
  logic [7:0] filter_select_r;
  logic [7:0] filter_select_nxt;
  logic dflt_r;
  logic dflt_nxt;
  logic hit_filter;
  logic [$clog2(`SETTLE_CYCLES + 1)-1:0] settle_cnt_r;
  logic [$clog2(`SETTLE_CYCLES + 1)-1:0] settle_cnt_nxt;
  logic settle_last;
  chan_state_t state_r;
  chan_state_t state_nxt;
  logic settling_nxt;

  // channel side
  logic signed [16:0] chan_raw [2];
  logic [15:0] result [2];

  // read ports
  logic hit_ch0;
  logic hit_ch1;
  logic hit_param;
  logic [15:0] image_word;
  logic [7:0] param_byte;
  logic [15:0] image_rdata_nxt;
  logic [7:0] param_rdata_nxt;
  logic image_ack_nxt;

  // field decode shared by both channels
  function automatic filter_mode_t mode_of(input logic [7:0] sel, input int lsb);
    mode_of = filter_mode_t'(sel[lsb +: 2]);
  endfunction : mode_of

  function automatic int lsb_of(input int ch);
    if (ch == 0) begin
      lsb_of = `FILT_CH0_LSB;
    end else begin
      lsb_of = `FILT_CH1_LSB;
    end
  endfunction : lsb_of

  // record write: only the filter fields are stored, the rest is dropped
  assign hit_filter = param_wr && (param_addr == `FILTER_SELECT_OFS);
  assign filter_select_nxt = hit_filter ? {4'h0, param_wdata[3:0]} :
                             filter_select_r;

  // the reset value 10h selects no filter in its fields, so the medium
  // filter is held by this flag until the first write to byte 1
  assign dflt_nxt = hit_filter ? 1'b0 : dflt_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      filter_select_r <= `FILTER_SELECT_RST;
    end else begin
      filter_select_r <= filter_select_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dflt_r <= 1'b1;
    end else begin
      dflt_r <= dflt_nxt;
    end
  end

  // settle window opens on every write to byte 1; another such write during settling restarts it
  assign settle_last = (settle_cnt_r == ($bits(settle_cnt_r))'(`SETTLE_CYCLES - 1));

  always_comb begin
    state_nxt = state_r;
    settle_cnt_nxt = settle_cnt_r;
    unique case (state_r)
      ST_RUN: begin
        if (hit_filter) begin
          state_nxt = ST_SETTLE;
          settle_cnt_nxt = '0;
        end
      end
      ST_SETTLE: begin
        if (hit_filter) begin
          settle_cnt_nxt = '0;
        end else if (settle_last) begin
          state_nxt = ST_RUN;
        end else begin
          settle_cnt_nxt = settle_cnt_r + 1'b1;
        end
      end
    endcase
  end

  assign settling_nxt = (state_nxt == ST_SETTLE);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      settle_cnt_r <= '0;
    end else begin
      settle_cnt_r <= settle_cnt_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      settling_r <= 1'b0;
    end else begin
      settling_r <= settling_nxt;
    end
  end

  // per-channel filter and format
  assign chan_raw[0] = raw_ch0;
  assign chan_raw[1] = raw_ch1;

  generate
    for (genvar g = 0; g < 2; g++) begin : g_chan
      filter_mode_t mode_w;
      assign mode_w = dflt_r ? FILT_MEDIUM :
                      mode_of(filter_select_r, lsb_of(g));
      chan_filter u_chan (
        .clk(clk),
        .rstn(rstn),
        .mode(mode_w),
        .settling(settling_r),
        .sample_stb(sample_stb),
        .raw_code(chan_raw[g]),
        .result_r(result[g])
      );
    end
  endgenerate

  // read ports: unmapped image words and reserved record bytes read zero
  assign hit_ch0 = (image_addr == `CH0_RESULT_ADDR);
  assign hit_ch1 = (image_addr == `CH1_RESULT_ADDR);
  assign image_word = hit_ch0 ? result[0] :
                      hit_ch1 ? result[1] :
                      16'h0000;
  assign image_rdata_nxt = image_rd ? image_word : image_rdata_r;
  assign image_ack_nxt = image_rd;
  assign hit_param = (param_addr == `FILTER_SELECT_OFS);
  assign param_byte = hit_param ? filter_select_r : 8'h00;
  assign param_rdata_nxt = param_rd ? param_byte : param_rdata_r;

  // read data holds until the next request, so a slow reader loses nothing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      image_rdata_r <= 16'h0000;
    end else begin
      image_rdata_r <= image_rdata_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      image_ack_r <= 1'b0;
    end else begin
      image_ack_r <= image_ack_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      param_rdata_r <= 8'h00;
    end else begin
      param_rdata_r <= param_rdata_nxt;
    end
  end
endmodule : analog_input_value_formatter

// ==== bench/ai_fmt_monitor.sv ====
/* port checker of the formatter; assumes a bind to its top module */
`timescale 1ns/1ps
module ai_fmt_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // record port
  input wire logic param_wr,
  input wire logic param_rd,
  input wire logic [7:0] param_addr,
  input wire logic [7:0] param_rdata_r,
  // image port
  input wire logic image_rd,
  input wire logic [15:0] image_addr,
  input wire logic [15:0] image_rdata_r,
  input wire logic image_ack_r,
  input wire logic settling_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire mapped = image_addr == 16'h0320 || image_addr == 16'h0322;
  a_ack_follows: assert property (image_rd |=> image_ack_r) else $error("no ack");
  a_ack_cause: assert property (image_ack_r |-> $past(image_rd)) else $error("stray ack");
  a_settle_start: assert property (param_wr && param_addr == 8'h01 |=> settling_r)
    else $error("no settling after write");
  // one settling cycle passes before the result word switches over
  a_settle_code: assert property (settling_r && $past(settling_r) && image_rd && mapped
    |=> image_rdata_r == 16'h7fff) else $error("word not 7fff while settling");
  a_low_zero: assert property (image_ack_r && image_rdata_r != 16'h7fff
    |-> image_rdata_r[3:0] == 4'h0)
    else $error("low bits set");
  a_word_hold: assert property (!image_rd |=> $stable(image_rdata_r)) else $error("word moved");
  a_rsvd_zero: assert property (param_rd && param_addr != 8'h01 |=> param_rdata_r == 8'h00)
    else $error("reserved byte not zero");
  a_unmapped_zero: assert property (image_rd && !mapped |=> image_rdata_r == 16'h0000)
    else $error("unmapped word not zero");
endmodule : ai_fmt_monitor
bind analog_input_value_formatter ai_fmt_monitor mon (.clk, .rstn, .param_wr, .param_rd,
  .param_addr, .param_rdata_r, .image_rd, .image_addr, .image_rdata_r, .image_ack_r, .settling_r);

// ==== bench/analog_source.sv ====
/* voltage sources of both channels; assumes millivolt settings from the bench */
`timescale 1ns/1ps
module analog_source (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // voltages in millivolts
  input wire logic signed [15:0] mv0,
  input wire logic signed [15:0] mv1,
  // converter side
  output logic sample_stb,
  output logic signed [16:0] raw_ch0,
  output logic signed [16:0] raw_ch1
);
  logic [1:0] div_r;
  // a new pair every 4 clocks, slower than the bus so reads see repeats
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) div_r <= 2'h0;
    else div_r <= div_r + 2'h1;
  end
  assign sample_stb = div_r == 2'h3;
  assign raw_ch0 = 17'(mv0 * 27648 / 10000);
  assign raw_ch1 = 17'(mv1 * 27648 / 10000);
endmodule : analog_source

// ==== bench/testbench.sv ====
/* self-checking bench of the formatter; assumes a 20 MHz clock and fixed settling */
`timescale 1ns/1ps
module testbench;
  logic clk = 0, rstn = 0, param_wr = 0, param_rd = 0, image_rd = 0;
  logic [7:0] param_addr = 0, param_wdata = 0, rb;
  logic [15:0] image_addr = 0;
  logic signed [15:0] mv0 = 0, mv1 = 0;
  wire [7:0] param_rdata_r;
  wire [15:0] image_rdata_r;
  wire image_ack_r, settling_r, sample_stb;
  wire signed [16:0] raw_ch0, raw_ch1;
  int bad_count = 0, num_checks = 0, cyc = 0;
  always #25 clk = ~clk;
  analog_source src (.clk, .rstn, .mv0, .mv1, .sample_stb, .raw_ch0, .raw_ch1);
  analog_input_value_formatter dut (.clk, .rstn, .sample_stb, .raw_ch0, .raw_ch1, .param_wr,
    .param_addr, .param_wdata, .param_rd, .param_rdata_r, .image_rd, .image_addr,
    .image_rdata_r, .image_ack_r, .settling_r);
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  // two settling windows of 40000 cycles each; the ceiling adds about an eighth
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    param_wr <= 1;
    param_addr <= a;
    param_wdata <= d;
    @(posedge clk);
    param_wr <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    param_rd <= 1;
    param_addr <= a;
    @(posedge clk);
    param_rd <= 0;
    #1 rb = param_rdata_r;
  endtask : rd
  task automatic img(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    image_rd <= 1;
    image_addr <= a;
    @(posedge clk);
    image_rd <= 0;
    #1 chk("ack", {15'h0, image_ack_r}, 16'h1);
    chk("word", image_rdata_r, exp);
  endtask : img
  task automatic t_reset_vals;
    rd(8'h01);
    chk("filter after reset", {8'h0, rb}, 16'h0010);
  endtask : t_reset_vals
  task automatic t_record;
    wr(8'h00, 8'hff);
    wr(8'h0c, 8'hff);
    rd(8'h00);
    chk("reserved byte", {8'h0, rb}, 16'h0000);
    img(16'h0324, 16'h0000);
    // channel 0 gets the unused filter code, channel 1 no filter
    wr(8'h01, 8'hf3);
    img(16'h0322, 16'h7fff);
    chk("settling", {15'h0, settling_r}, 16'h1);
    rd(8'h01);
    chk("filter upper bits", {8'h0, rb}, 16'h0003);
    repeat (40010) @(posedge clk);
    #1 chk("settled", {15'h0, settling_r}, 16'h0);
    img(16'h0320, 16'h7fff);
    img(16'h0322, 16'h0000);
    wr(8'h01, 8'h00);
    repeat (40010) @(posedge clk);
    #1 chk("settled again", {15'h0, settling_r}, 16'h0);
  endtask : t_record
  task automatic t_levels;
    logic signed [15:0] v [8] = '{10000, 5000, 0, 11759, 12500, -1000, -500, -800};
    logic [15:0] e [8] = '{16'h6c00, 16'h3600, 16'h0000, 16'h7ef0, 16'h7fff, 16'h8000,
      16'hfa90, 16'hf750};
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      mv0 <= v[i];
      mv1 <= v[7 - i];
      repeat (20) @(posedge clk);
      img(16'h0320, e[i]);
      img(16'h0322, e[7 - i]);
    end
  endtask : t_levels
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1;
    t_reset_vals();
    t_record();
    t_levels();
    conclude();
  end
endmodule : testbench
